// *** src/sacc_top.sv ***
// Converter and comparator control: approximation engine, flag and accumulator transfers
//
// Contract
// - Converter start clears the whole result register before any trial.
// - Then the top bit is set and the DAC level compared with input.
// - Bit stays one when DAC below input, cleared when DAC above input.
// - Trials run from top bit to bit zero, ten comparisons in all.
// - Conversion ends 62 machine cycles after start, result held.
// - On completion the done flag sets and the interrupt condition asserts.
// - Control one bit 3 high selects comparator mode.
// - Threshold load takes upper nibble from B, lower from A.
// - In comparator mode the DAC code comes from the threshold register.
// - Result is undefined after changing into comparator mode.
// - Threshold is separate storage and survives mode changes.
// - Threshold write and read act only in comparator mode.
// - In comparator mode flag sets when input is below DAC level.
// - Flag clears when its interrupt is taken or skip happens.
// - Interrupt control two setting chooses interrupt or skip service.
// - Comparator start ends after 8 machine cycles, then updates flag.
// - Low-pair read puts result bits 1:0 into A upper, zeros below.
// - Flag may set on mode return; software clears it with skip.
// - Control one bit 3 low selects converter mode.
// - Three-bit field selects one of eight analog inputs.
// - Result is 10 bits; value n drives DAC to n/1024 full scale.
`timescale 1ns/1ps
module sacc_top
	import sacc_pkg::*;
#(
	parameter int MCD = sacc_pkg::MC_DIV
) (
	input  wire logic                       mclk_in,
	input  wire logic                       reset_n_in,
	input  wire logic [sacc_pkg::NIB_W-1:0] acc_a_in,
	input  wire logic [sacc_pkg::NIB_W-1:0] acc_b_in,
	input  wire logic                       ctrl_one_write_in,
	input  wire logic                       ctrl_one_read_in,
	input  wire logic                       conv_start_instr_in,
	input  wire logic                       set_threshold_instr_in,
	input  wire logic                       read_threshold_instr_in,
	input  wire logic                       fetch_low_pair_instr_in,
	input  wire logic                       fetch_high_byte_instr_in,
	input  wire logic                       skip_on_done_instr_in,
	input  wire logic                       done_irq_sel_in,
	input  wire logic                       irq_taken_in,
	input  wire logic                       comparator_in,
	output logic [sacc_pkg::NIB_W-1:0]      acc_a_out,
	output logic [sacc_pkg::NIB_W-1:0]      acc_b_out,
	output logic                            acc_valid_out,
	output logic                            skip_out,
	output logic                            done_irq_req_out,
	output logic                            conv_done_flag_out,
	output logic [sacc_pkg::RES_W-1:0]      dac_code_out,
	output logic [sacc_pkg::SEL_W-1:0]      analog_sel_out,
	output logic                            comp_mode_out,
	output logic                            busy_out
);
	import sacc_pkg::*;

	sacc_state_t           state_reg;
	logic                  mc_en;
	logic [NIB_W-1:0]      ctrl_one_reg;
	logic [RES_W-1:0]      result_reg;
	logic [THR_W-1:0]      thresh_reg;
	logic [CNT_W-1:0]      cnt_reg;
	logic [SUB_W-1:0]      sub_reg;
	logic [IDX_W-1:0]      idx_reg;
	logic                  trials_reg;
	logic                  cmp_meta_reg;
	logic                  cmp_sync_reg;
	logic                  comp_mode;
	logic                  start_ok;
	logic                  conv_end;
	logic                  cmp_end;
	logic                  flag_set;
	logic                  flag_clr;

	function automatic logic [RES_W-1:0] dac_from_thresh(input logic [THR_W-1:0] t);
		dac_from_thresh = {t, {(RES_W - THR_W){1'b0}}};
	endfunction

	sacc_mc_tick #(
		.DIV (MCD)
	) u_tick (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.tick_out   (mc_en)
	);

	assign comp_mode = ctrl_one_reg[MODE_BIT];
	// Start ignored while busy so a running sequence is never restarted
	assign start_ok  = conv_start_instr_in && (state_reg == SACC_IDLE);
	assign conv_end  = (state_reg == SACC_CONV) && mc_en && (cnt_reg == CONV_CYCLES - 6'h01);
	assign cmp_end   = (state_reg == SACC_CMP) && mc_en && (cnt_reg == CMP_CYCLES - 6'h01);
	// Comparator high means DAC level below the input
	assign flag_set  = conv_end || (cmp_end && !cmp_sync_reg);
	assign flag_clr  = (irq_taken_in && done_irq_sel_in)
		|| (skip_on_done_instr_in && !done_irq_sel_in && conv_done_flag_out);

	// Comparator output is asynchronous to the machine clock
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= comparator_in;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_one_reg <= CTRL_ONE_RESET;
		end else if (ctrl_one_write_in) begin
			ctrl_one_reg <= acc_a_in;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			thresh_reg <= THRESH_RESET;
		end else if (set_threshold_instr_in && comp_mode) begin
			thresh_reg <= {acc_b_in, acc_a_in};
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= SACC_IDLE;
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				SACC_IDLE: begin
					if (start_ok) begin
						state_reg <= comp_mode ? SACC_CMP : SACC_CONV;
						cnt_reg   <= '0;
					end
				end
				SACC_CONV: begin
					if (mc_en) begin
						cnt_reg <= cnt_reg + 6'h01;
					end
					if (conv_end) begin
						state_reg <= SACC_DONE;
					end
				end
				SACC_CMP: begin
					if (mc_en) begin
						cnt_reg <= cnt_reg + 6'h01;
					end
					if (cmp_end) begin
						state_reg <= SACC_DONE;
					end
				end
				SACC_DONE: begin
					state_reg <= SACC_IDLE;
				end
			endcase
		end
	end

	// Approximation engine; result left untouched in comparator mode, so its
	// content there carries no meaning
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			result_reg <= RESULT_RESET;
			idx_reg    <= MSB_IDX;
			sub_reg    <= '0;
			trials_reg <= 1'b0;
		end else if (start_ok && !comp_mode) begin
			result_reg <= RESULT_RESET;
			idx_reg    <= MSB_IDX;
			sub_reg    <= '0;
			trials_reg <= 1'b1;
		end else if (state_reg == SACC_CONV && mc_en && trials_reg) begin
			if (sub_reg == '0) begin
				result_reg[idx_reg] <= 1'b1;
			end
			if (sub_reg == STEP_LEN - 3'h1) begin
				result_reg[idx_reg] <= cmp_sync_reg;
				sub_reg             <= '0;
				if (idx_reg == '0) begin
					trials_reg <= 1'b0;
				end else begin
					idx_reg <= idx_reg - 4'h1;
				end
			end else begin
				sub_reg <= sub_reg + 3'h1;
			end
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			conv_done_flag_out <= 1'b0;
		end else if (flag_set) begin
			conv_done_flag_out <= 1'b1;
		end else if (flag_clr) begin
			conv_done_flag_out <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			done_irq_req_out <= 1'b0;
			skip_out         <= 1'b0;
		end else begin
			done_irq_req_out <= done_irq_sel_in && (flag_set || (conv_done_flag_out && !flag_clr));
			skip_out         <= skip_on_done_instr_in && !done_irq_sel_in && conv_done_flag_out;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_out <= 1'b0;
		end else if (start_ok) begin
			busy_out <= 1'b1;
		end else if (conv_end || cmp_end) begin
			busy_out <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dac_code_out   <= RESULT_RESET;
			analog_sel_out <= '0;
			comp_mode_out  <= 1'b0;
		end else begin
			dac_code_out   <= comp_mode ? dac_from_thresh(thresh_reg) : result_reg;
			analog_sel_out <= ctrl_one_reg[SEL_LSB +: SEL_W];
			comp_mode_out  <= comp_mode;
		end
	end

	// Accumulator transfers; a disallowed threshold read leaves the bus untouched
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acc_a_out     <= '0;
			acc_b_out     <= '0;
			acc_valid_out <= 1'b0;
		end else begin
			acc_valid_out <= 1'b0;
			if (fetch_low_pair_instr_in) begin
				acc_a_out     <= {result_reg[1:0], 2'b00};
				acc_valid_out <= 1'b1;
			end else if (fetch_high_byte_instr_in) begin
				acc_b_out     <= result_reg[9:6];
				acc_a_out     <= result_reg[5:2];
				acc_valid_out <= 1'b1;
			end else if (read_threshold_instr_in && comp_mode) begin
				acc_b_out     <= thresh_reg[7:4];
				acc_a_out     <= thresh_reg[3:0];
				acc_valid_out <= 1'b1;
			end else if (ctrl_one_read_in) begin
				acc_a_out     <= ctrl_one_reg;
				acc_valid_out <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_conv_start;
		start_ok && !comp_mode;
	endsequence

	sequence s_cleared;
		result_reg == RESULT_RESET && busy_out;
	endsequence

	property p_clear_first;
		s_conv_start |=> s_cleared;
	endproperty
	a_clear_first: assert property (p_clear_first) else $error("result not cleared at start");

	property p_msb_trial;
		(state_reg == SACC_CONV && mc_en && trials_reg && idx_reg == MSB_IDX && sub_reg == '0)
			|=> result_reg[9];
	endproperty
	a_msb_trial: assert property (p_msb_trial) else $error("top bit not tried");

	property p_decide;
		(state_reg == SACC_CONV && mc_en && trials_reg && sub_reg == STEP_LEN - 3'h1)
			|=> result_reg[$past(idx_reg)] == $past(cmp_sync_reg);
	endproperty
	a_decide: assert property (p_decide) else $error("trial bit decided wrongly");

	property p_conv_end;
		conv_end |-> !trials_reg ##1 (conv_done_flag_out && !busy_out);
	endproperty
	a_conv_end: assert property (p_conv_end) else $error("conversion end wrong");

	property p_cmp_end;
		cmp_end |=> !busy_out && (conv_done_flag_out == ($past(conv_done_flag_out)
			&& !$past(flag_clr) || !$past(cmp_sync_reg)));
	endproperty
	a_cmp_end: assert property (p_cmp_end) else $error("comparison outcome wrong");

	property p_thresh_load;
		(set_threshold_instr_in && comp_mode) |=> thresh_reg == {$past(acc_b_in), $past(acc_a_in)};
	endproperty
	a_thresh_load: assert property (p_thresh_load) else $error("threshold load wrong");

	property p_thresh_hold;
		!(set_threshold_instr_in && comp_mode) |=> $stable(thresh_reg);
	endproperty
	a_thresh_hold: assert property (p_thresh_hold) else $error("threshold changed");

	property p_dac_src;
		comp_mode ##1 comp_mode |-> dac_code_out == dac_from_thresh($past(thresh_reg));
	endproperty
	a_dac_src: assert property (p_dac_src) else $error("dac source wrong");

	property p_flag_clear;
		(flag_clr && !flag_set) |=> !conv_done_flag_out;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_low_pair;
		fetch_low_pair_instr_in |=> acc_valid_out && acc_a_out == {$past(result_reg[1:0]), 2'b00};
	endproperty
	a_low_pair: assert property (p_low_pair) else $error("low pair read wrong");

	property p_busy;
		start_ok |=> busy_out [*2];
	endproperty
	a_busy: assert property (p_busy) else $error("busy not held");

endmodule

// *** src/sacc_pkg.sv ***
// Shared constants and types for the successive-approximation converter control
package sacc_pkg;

	localparam int RES_W     = 10;
	localparam int THR_W     = 8;
	localparam int NIB_W     = 4;
	localparam int SEL_W     = 3;
	localparam int CNT_W     = 6;
	localparam int IDX_W     = 4;
	localparam int SUB_W     = 3;

	// Machine cycles per operation
	localparam logic [CNT_W-1:0] CONV_CYCLES = 6'h3e;
	localparam logic [CNT_W-1:0] CMP_CYCLES  = 6'h08;
	// Each of the ten trials lasts this many machine cycles; 10 x 6 fits inside 62
	localparam logic [SUB_W-1:0] STEP_LEN    = 3'h6;
	localparam logic [IDX_W-1:0] MSB_IDX     = 4'h9;

	// Control register one fields
	localparam int MODE_BIT = 3;
	localparam int SEL_LSB  = 0;
	localparam logic [NIB_W-1:0] CTRL_ONE_RESET = 4'h0;
	localparam logic [RES_W-1:0] RESULT_RESET   = 10'h000;
	localparam logic [THR_W-1:0] THRESH_RESET   = 8'h00;

	// Machine-cycle divider ratio in clocks
	localparam int MC_DIV = 1;

	typedef enum logic [1:0] {
		SACC_IDLE = 2'b00,
		SACC_CONV = 2'b01,
		SACC_DONE = 2'b11,
		SACC_CMP  = 2'b10
	} sacc_state_t;

endpackage

// *** src/sacc_mc_tick.sv ***
// Machine-cycle enable divider
`timescale 1ns/1ps
module sacc_mc_tick #(
	parameter int DIV = 1
) (
	input  wire logic mclk_in,
	input  wire logic reset_n_in,
	output logic      tick_out
);
	localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;

	logic [DW-1:0] div_reg;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			div_reg <= '0;
		end else if (div_reg == DW'(DIV - 1)) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + 1'b1;
		end
	end

	// Registered so the pulse is glitch-free; DIV of 1 gives a steady high
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_out <= 1'b0;
		end else begin
			tick_out <= (DIV <= 1) ? 1'b1 : (div_reg == DW'(DIV - 1));
		end
	end
endmodule

// *** tb/sacc_analog_model.sv ***
// Analog front end model: per-channel input levels against the DAC code
`timescale 1ns/1ps
module sacc_analog_model
	import sacc_pkg::*;
(
	input  wire logic [sacc_pkg::RES_W-1:0] dac_code_in,
	input  wire logic [sacc_pkg::SEL_W-1:0] sel_in,
	output logic                            comparator_out
);
	import sacc_pkg::*;

	logic [RES_W-1:0] level [8];

	initial foreach (level[i]) level[i] = 10'h155;

	// Strict compare; levels sit off the comparator-mode grid of multiples of four, so ties occur only during conversion trials
	assign comparator_out = dac_code_in < level[sel_in];
endmodule

// *** tb/sacc_top_tb_top.sv ***
// Self-checking bench for the converter and comparator control
`timescale 1ns/1ps
module sacc_top_tb_top;
	import sacc_pkg::*;

	logic             mclk_in    = 1'b0;
	logic             reset_n_in = 1'b0;
	logic [NIB_W-1:0] acc_a      = 4'h0;
	logic [NIB_W-1:0] acc_b      = 4'h0;
	logic [8:0]       ins        = 9'h000;
	logic             irq_sel    = 1'b0;
	logic             cmp;
	logic [NIB_W-1:0] a_o;
	logic [NIB_W-1:0] b_o;
	logic             av;
	logic             sk;
	logic             irq;
	logic             flag;
	logic             cm;
	logic             busy;
	logic [RES_W-1:0] dac;
	logic [SEL_W-1:0] sel;
	logic [THR_W-1:0] thr_last;
	int               n_fail     = 0;
	int               checked    = 0;
	integer           seed       = 6;

	always #20 mclk_in = ~mclk_in;

	sacc_top #(.MCD(1)) sacc_top_i (
		.mclk_in                 (mclk_in),
		.reset_n_in              (reset_n_in),
		.acc_a_in                (acc_a),
		.acc_b_in                (acc_b),
		.ctrl_one_write_in       (ins[0]),
		.ctrl_one_read_in        (ins[1]),
		.conv_start_instr_in     (ins[2]),
		.set_threshold_instr_in  (ins[3]),
		.read_threshold_instr_in (ins[4]),
		.fetch_low_pair_instr_in (ins[5]),
		.fetch_high_byte_instr_in(ins[6]),
		.skip_on_done_instr_in   (ins[7]),
		.done_irq_sel_in         (irq_sel),
		.irq_taken_in            (ins[8]),
		.comparator_in           (cmp),
		.acc_a_out               (a_o),
		.acc_b_out               (b_o),
		.acc_valid_out           (av),
		.skip_out                (sk),
		.done_irq_req_out        (irq),
		.conv_done_flag_out      (flag),
		.dac_code_out            (dac),
		.analog_sel_out          (sel),
		.comp_mode_out           (cm),
		.busy_out                (busy)
	);

	sacc_analog_model sacc_analog_model_i (
		.dac_code_in   (dac),
		.sel_in        (sel),
		.comparator_out(cmp)
	);

	task automatic chk(input string nm, input logic [RES_W:0] seen, input logic [RES_W:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// One instruction: a cycle gap first so no pulse is redriven in one step
	task automatic op(input int k, input logic [3:0] a, input logic [3:0] b);
		@(posedge mclk_in);
		#1 acc_a = a;
		acc_b = b;
		ins = 9'h001 << k;
		@(posedge mclk_in);
		#1 ins = 9'h000;
	endtask

	task automatic wait_idle(output int n);
		n = 0;
		while (busy === 1'b1 && n < 200) begin
			@(posedge mclk_in);
			#1 n++;
		end
	endtask

	function automatic logic [RES_W-1:0] sar(input logic [RES_W-1:0] v);
		logic [RES_W-1:0] r;
		r = '0;
		for (int i = RES_W - 1; i >= 0; i--) begin
			r[i] = 1'b1;
			if (!(r < v)) r[i] = 1'b0;
		end
		return r;
	endfunction

	task automatic convert(input logic [2:0] ch, input logic [9:0] v, input logic im);
		int               n;
		int               m;
		logic [RES_W-1:0] e;
		e = sar(v);
		sacc_analog_model_i.level[ch] = v;
		irq_sel = im;
		op(0, {1'b0, ch}, 4'h0);
		op(2, 4'h0, 4'h0);
		chk("busy", busy, 1'b1);
		m = 0;
		while (dac !== 10'h200 && m < 4) begin
			@(posedge mclk_in);
			#1 m++;
		end
		chk("first trial", dac, 10'h200);
		// Second start mid-run must not restart the count
		op(2, 4'h0, 4'h0);
		wait_idle(n);
		chk("conv cycles", (RES_W + 1)'(n + m + 2), (RES_W + 1)'(CONV_CYCLES));
		chk("flag", flag, 1'b1);
		chk("irq", irq, im);
		chk("sel", sel, ch);
		chk("dac", dac, e);
		op(5, 4'h0, 4'h0);
		chk("low", {av, a_o}, {1'b1, e[1:0], 2'b00});
		op(6, 4'h0, 4'h0);
		chk("high", {b_o, a_o}, e[9:2]);
		op(7, 4'h0, 4'h0);
		chk("skip", sk, !im);
		chk("flag after skip", flag, im);
		if (im) begin
			op(8, 4'h0, 4'h0);
			chk("irq clear", {flag, irq}, 2'b00);
		end
	endtask

	task automatic compare(input logic [7:0] t, input logic [9:0] v);
		int n;
		sacc_analog_model_i.level[0] = v;
		irq_sel = 1'b0;
		op(0, 4'h8, 4'h0);
		op(3, t[3:0], t[7:4]);
		op(4, 4'h0, 4'h0);
		chk("thr", {av, b_o, a_o}, {1'b1, t});
		op(7, 4'h0, 4'h0);
		chk("mode", cm, 1'b1);
		chk("cmp dac", dac, {t, 2'b00});
		op(2, 4'h0, 4'h0);
		wait_idle(n);
		chk("cmp cycles", (RES_W + 1)'(n), (RES_W + 1)'(CMP_CYCLES));
		chk("cmp flag", flag, v < {t, 2'b00});
		thr_last = t;
	endtask

	initial begin
		#(40 * 20000);
		n_fail++;
		report_and_stop;
	end

	initial begin
		logic [31:0] r;
		repeat (5) @(posedge mclk_in);
		#1 reset_n_in = 1'b1;
		chk("reset", {flag, busy, cm, irq}, 4'h0);
		chk("reset dac", dac, 10'h000);
		convert(3'h4, 10'h3fe, 1'b0);
		convert(3'h0, 10'h002, 1'b1);
		repeat (6) begin
			r = $random(seed);
			convert(r[2:0], (r[19:10] & 10'h3fc) | 10'h002, r[31]);
		end
		op(4, 4'h0, 4'h0);
		chk("thr refused", av, 1'b0);
		compare(8'hff, 10'h3fe);
		compare(8'h00, 10'h002);
		repeat (6) begin
			r = $random(seed);
			compare(r[7:0], (r[19:10] & 10'h3fc) | 10'h002);
		end
		irq_sel = 1'b0;
		op(0, 4'h0, 4'h0);
		op(7, 4'h0, 4'h0);
		op(3, ~thr_last[3:0], ~thr_last[7:4]);
		op(1, 4'h0, 4'h0);
		chk("ctrl read", {av, a_o, cm}, {1'b1, 4'h0, 1'b0});
		op(0, 4'h8, 4'h0);
		op(4, 4'h0, 4'h0);
		chk("thr kept", {b_o, a_o}, thr_last);
		// Reset in mid-comparison must return flag, busy, mode, interrupt request, valid and threshold to their idle values
		op(2, 4'h0, 4'h0);
		@(posedge mclk_in);
		#1 reset_n_in = 1'b0;
		repeat (2) @(posedge mclk_in);
		#1 reset_n_in = 1'b1;
		chk("mid reset", {flag, busy, cm, irq, av}, 5'h00);
		op(0, 4'h8, 4'h0);
		op(4, 4'h0, 4'h0);
		chk("thr after reset", {av, b_o, a_o}, {1'b1, THRESH_RESET});
		report_and_stop;
	end
endmodule
